/* File: verilog/aadc_top.v */
// converter post-processing: input select,
// differential coding, averaging, comparators
// assumes converter, sequencer FIFO and PWM
// all run on the same 16 MHz clock
`timescale 1ns/1ps
`default_nettype none
`include "aadc_map.vh"

module aadc_top
(
  input wire clk,
  input wire rst,
  // reference select control bit
  input wire converter_control_reg_vref,
  // averaging control field, power of two
  input wire [2:0] sample_averaging_control,
  // eight step nibbles: diff, end, ie, ts
  input wire [31:0] sequence_step_control,
  // eight step input-select nibbles
  input wire [31:0] sequence_input_select,
  // per-step comparator routing
  input wire [7:0] step_compare_enable,
  input wire [23:0] step_compare_select,
  // sequence start pulse
  input wire seq_trigger,
  // converter handshake
  output wire conv_start,
  input wire conv_done,
  input wire [9:0] conv_pos_data,
  input wire [9:0] conv_neg_data,
  // analog front-end selection
  output reg ext_ref_select,
  output reg [3:0] mux_pos_select,
  output reg [3:0] mux_neg_select,
  output reg diff_enable,
  output reg temp_select,
  // sequencer FIFO write side
  output reg fifo_write,
  output reg [9:0] fifo_data,
  output reg [2:0] fifo_step,
  output reg step_interrupt,
  output reg seq_busy,
  // comparator configuration, flattened
  input wire [79:0] lower_limit,
  input wire [79:0] upper_limit,
  input wire [7:0] cmp_int_enable,
  input wire [7:0] cmp_trig_enable,
  input wire [15:0] cmp_int_mode,
  input wire [15:0] cmp_int_band,
  input wire [15:0] cmp_trig_mode,
  input wire [15:0] cmp_trig_band,
  // comparator outputs
  output wire [7:0] cmp_interrupt,
  output wire [7:0] cmp_trigger
);

  // ==========================================
  // sequence state machine codes
  localparam ST_IDLE = 2'h0;
  localparam ST_START = 2'h1;
  localparam ST_WAIT = 2'h2;
  localparam ST_SETTLE = 2'h3;

  // current state and its next value
  reg [1:0] state_q;
  reg [1:0] state_d;
  // current step and its next value
  reg [2:0] step_q;
  reg [2:0] step_d;
  // start pulse to the converter
  reg start_q;
  // clears the averager at sequence start
  reg clear_q;
  // averaged entry strobe from the averager
  wire avg_valid;
  // averaged entry value from the averager
  wire [9:0] avg_data;

  // ==========================================
  // per-step configuration picked by step
  // current control nibble
  wire [3:0] ctl_nib = sequence_step_control[step_q*4 +: 4];
  // current input-select nibble
  wire [3:0] sel_nib = sequence_input_select[step_q*4 +: 4];
  // last step reached, either by flag or wrap
  wire last_step = ctl_nib[`AADC_NIB_END] || (step_q == 3'h7);
  // nibbles of the step about to be started;
  // step_d already holds the step that the
  // coming conversion belongs to
  // control nibble for the coming start
  wire [3:0] nxt_ctl = sequence_step_control[step_d*4 +: 4];
  // input-select nibble for the coming start
  wire [3:0] nxt_sel = sequence_input_select[step_d*4 +: 4];

  // ==========================================
  // reference select
  // the code range does not depend on it, so
  // nothing downstream looks at this bit
  // drive reference choice
  always @(posedge clk)
  begin
    if (rst)
      ext_ref_select <= 1'b0;
    else
      ext_ref_select <= converter_control_reg_vref;
  end

  // ==========================================
  // sequence state machine
  always @*
  begin
    state_d = state_q;
    step_d = step_q;
    case (state_q)
      ST_IDLE:
      begin
        // wait for a sequence start
        if (seq_trigger)
        begin
          state_d = ST_START;
          step_d = 3'h0;
        end
      end
      ST_START:
        // one conversion requested
        state_d = ST_WAIT;
      ST_WAIT:
      begin
        // converter still working
        if (conv_done)
          state_d = ST_SETTLE;
      end
      ST_SETTLE:
      begin
        if (avg_valid && last_step)
          state_d = ST_IDLE;
        else if (avg_valid)
        begin
          state_d = ST_START;
          step_d = step_q + 3'h1;
        end
        else
          // repeat the same step for averaging
          state_d = ST_START;
      end
      default:
        state_d = ST_IDLE;
    endcase
  end

  // ==========================================
  // state registers
  // conv_start and busy are decoded from the next
  // state, the clear strobe from idle and trigger,
  // so they line up with the state change itself and
  // no extra cycle of latency is added
  always @(posedge clk)
  begin
    if (rst)
    begin
      state_q <= ST_IDLE;
      step_q <= 3'h0;
      start_q <= 1'b0;
      clear_q <= 1'b0;
      seq_busy <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      step_q <= step_d;
      start_q <= (state_d == ST_START);
      // a fresh sequence drops any partial sum
      clear_q <= (state_q == ST_IDLE) && seq_trigger;
      seq_busy <= (state_d != ST_IDLE);
    end
  end

  // converter start follows the state directly
  assign conv_start = start_q;

  // ==========================================
  // analog input selection, set with start
  // the nibbles come from the step that the
  // coming start will convert, not the one
  // that just finished, so a step advance or
  // a fresh sequence never converts with the
  // previous step's input selection
  always @(posedge clk)
  begin
    if (rst)
    begin
      mux_pos_select <= 4'h0;
      mux_neg_select <= 4'h0;
      diff_enable <= 1'b0;
      temp_select <= 1'b0;
    end
    else if (state_d == ST_START)
    begin
      diff_enable <= nxt_ctl[`AADC_NIB_DIFF];
      temp_select <= nxt_ctl[`AADC_NIB_TS];
      if (nxt_ctl[`AADC_NIB_DIFF])
      begin
        // even positive pair
        // only the low three bits count, so no
        // other pairing can be formed
        mux_pos_select <= {nxt_sel[2:0], 1'b0};
        mux_neg_select <= {nxt_sel[2:0], 1'b1};
      end
      else
      begin
        // single-ended: negative side unused
        mux_pos_select <= nxt_sel;
        mux_neg_select <= 4'h0;
      end
    end
  end

  // ==========================================
  // result coding
  // the halving loses the lowest bit of the
  // difference, so the top code is 0x3FE; a
  // wider code would not fit the FIFO entry
  // difference in eleven bits, two's complement
  wire [10:0] delta = {1'b0, conv_pos_data} - {1'b0, conv_neg_data};
  // halve so +/- full scale fits the code
  wire [10:0] half = {delta[10], delta[10:1]};
  // shift zero difference to mid code
  wire [10:0] offs = half + `AADC_DIFF_MID;
  // offset-coded difference
  // only the -1023 corner goes below zero
  wire [9:0] diff_code = offs[10] ? `AADC_CODE_MIN : offs[9:0];
  wire [9:0] conv_code = diff_enable ? diff_code : conv_pos_data;

  // ==========================================
  // shared averager
  // one instance serves every step and every
  // input kind, so the field cannot differ
  // between single-ended and differential steps
  // the trade is throughput: each entry costs
  // N conversions of the same step

  // one averager, shift 0 passes
  // a field of 0 keeps N at one, so the reset
  // value lets each conversion through as is
  aadc_avg u_avg
  (
    .clk(clk),
    .rst(rst),
    .clear(clear_q),
    .shift(sample_averaging_control),
    .in_valid(conv_done && (state_q == ST_WAIT)),
    .in_data(conv_code),
    .out_valid(avg_valid),
    .out_data(avg_data)
  );

  // ==========================================
  // FIFO write and step interrupt
  // no back-pressure here: the FIFO reports
  // its own overflow when it cannot take one
  always @(posedge clk)
  begin
    if (rst)
    begin
      fifo_write <= 1'b0;
      fifo_data <= 10'h000;
      fifo_step <= 3'h0;
      step_interrupt <= 1'b0;
    end
    else
    begin
      fifo_write <= avg_valid;
      step_interrupt <= avg_valid && ctl_nib[`AADC_NIB_IE];
      if (avg_valid)
      begin
        fifo_data <= avg_data;
        fifo_step <= step_q;
      end
    end
  end

  // ==========================================
  // comparator routing for the current step
  // comparator chosen for this step
  wire [2:0] cmp_sel = step_compare_select[step_q*3 +: 3];
  // entry goes to a comparator, not only FIFO
  wire cmp_go = avg_valid && step_compare_enable[step_q];

  // ==========================================
  // comparator bank
  // each comparator runs two independent
  // functions on the same conversion data
  // the two functions keep separate state, so
  // enabling one never disturbs the other; a
  // step routes to one comparator only, which
  // keeps at most one bit of each bank high
  genvar gi;
  generate
    for (gi = 0; gi < `AADC_NCMP; gi = gi + 1)
    begin : g_cmp
      // this comparator is selected
      wire pick = cmp_go && (cmp_sel == gi);

      aadc_cmp u_int
      (
        .clk(clk),
        .rst(rst),
        .enable(cmp_int_enable[gi]),
        .in_valid(pick),
        .in_data(avg_data),
        .lower_limit(lower_limit[gi*10 +: 10]),
        .upper_limit(upper_limit[gi*10 +: 10]),
        .mode(cmp_int_mode[gi*2 +: 2]),
        .band(cmp_int_band[gi*2 +: 2]),
        .hit(cmp_interrupt[gi])
      );

      aadc_cmp u_trig
      (
        .clk(clk),
        .rst(rst),
        .enable(cmp_trig_enable[gi]),
        .in_valid(pick),
        .in_data(avg_data),
        .lower_limit(lower_limit[gi*10 +: 10]),
        .upper_limit(upper_limit[gi*10 +: 10]),
        .mode(cmp_trig_mode[gi*2 +: 2]),
        .band(cmp_trig_band[gi*2 +: 2]),
        .hit(cmp_trigger[gi])
      );
    end
  endgenerate

endmodule
`default_nettype wire

/* File: common/aadc_map.vh */
// constants for the converter post-processing block
// assumes a single 16 MHz converter clock domain
`ifndef AADC_MAP_VH
`define AADC_MAP_VH

// ==========================================
// data widths and codes
`define AADC_DW 10
`define AADC_ACCW 16
`define AADC_CODE_MIN 10'h000
`define AADC_CODE_MAX 10'h3FF
`define AADC_DIFF_MID 11'h1FF
`define AADC_NCMP 8
`define AADC_NSTEP 8

// ==========================================
// averaging control field
`define AADC_SAC_W 3
`define AADC_SAC_OFF 3'h0
`define AADC_SAC_MAX 3'h6

// ==========================================
// step control nibble bit positions
`define AADC_NIB_DIFF 0
`define AADC_NIB_END 1
`define AADC_NIB_IE 2
`define AADC_NIB_TS 3

// ==========================================
// comparator bands and modes
`define AADC_BAND_LOW 2'h0
`define AADC_BAND_MID 2'h1
`define AADC_BAND_HIGH 2'h3
`define AADC_MODE_ALWAYS 2'h0
`define AADC_MODE_ONCE 2'h1
`define AADC_MODE_HALWAYS 2'h2
`define AADC_MODE_HONCE 2'h3

`endif

/* File: verilog/aadc_avg.v */
// shared sample averager for every sequence step
// assumes in_valid is a one-cycle pulse per conversion
`timescale 1ns/1ps
`default_nettype none
`include "aadc_map.vh"

module aadc_avg
(
  input wire clk,
  input wire rst,
  input wire clear,
  input wire [2:0] shift,
  input wire in_valid,
  input wire [9:0] in_data,
  output reg out_valid,
  output reg [9:0] out_data
);

  // running sum, wide enough for 64 full codes
  reg [15:0] acc_q;
  // conversions taken so far
  reg [6:0] cnt_q;
  // clamp the field so no count passes 64
  wire [2:0] sh = (shift > `AADC_SAC_MAX) ? `AADC_SAC_MAX : shift;
  wire [6:0] target = 7'h01 << sh;
  wire [15:0] sum = acc_q + {6'h00, in_data};
  wire [15:0] quo = sum >> sh;

  // ==========================================
  // accumulate and emit
  // accumulate then divide
  always @(posedge clk)
  begin
    if (rst || clear)
    begin
      acc_q <= 16'h0000;
      cnt_q <= 7'h00;
      out_valid <= 1'b0;
      out_data <= 10'h000;
    end
    else if (in_valid && (cnt_q + 7'h01 == target))
    begin
      // last of the group: emit and restart
      acc_q <= 16'h0000;
      cnt_q <= 7'h00;
      out_valid <= 1'b1;
      out_data <= quo[9:0];
    end
    else if (in_valid)
    begin
      acc_q <= sum;
      cnt_q <= cnt_q + 7'h01;
      out_valid <= 1'b0;
    end
    else
      out_valid <= 1'b0;
  end

endmodule
`default_nettype wire

/* File: verilog/aadc_cmp.v */
// one comparator function (interrupt or trigger path)
// assumes limits hold upper >= lower
`timescale 1ns/1ps
`default_nettype none
`include "aadc_map.vh"

module aadc_cmp
(
  input wire clk,
  input wire rst,
  input wire enable,
  input wire in_valid,
  input wire [9:0] in_data,
  input wire [9:0] lower_limit,
  input wire [9:0] upper_limit,
  input wire [1:0] mode,
  input wire [1:0] band,
  output reg hit
);

  // previous conversion met the criterion
  reg prev_q;
  // hysteresis latched, cleared by opposite band
  reg hyst_q;
  wire is_low = in_data <= lower_limit;
  wire is_high = in_data > upper_limit;
  wire is_mid = !is_low && !is_high;
  reg met;
  reg opp;
  reg fire;

  // ==========================================
  // criterion and mode decode
  always @*
  begin
    met = 1'b0;
    opp = 1'b0;
    case (band)
      `AADC_BAND_LOW:
      begin
        met = is_low;
        opp = is_high;
      end
      `AADC_BAND_MID: met = is_mid;
      `AADC_BAND_HIGH:
      begin
        met = is_high;
        opp = is_low;
      end
      default: met = 1'b0;
    endcase
    case (mode)
      `AADC_MODE_ALWAYS: fire = met;
      `AADC_MODE_ONCE: fire = met && !prev_q;
      `AADC_MODE_HALWAYS: fire = met || (hyst_q && !opp);
      `AADC_MODE_HONCE: fire = met && !hyst_q && !prev_q;
      default: fire = 1'b0;
    endcase
  end

  // ==========================================
  // state update per monitored conversion
  always @(posedge clk)
  begin
    if (rst || !enable)
    begin
      prev_q <= 1'b0;
      hyst_q <= 1'b0;
      hit <= 1'b0;
    end
    else if (in_valid)
    begin
      prev_q <= met;
      hyst_q <= opp ? 1'b0 : (met | hyst_q);
      hit <= fire;
    end
    else
      hit <= 1'b0;
  end

endmodule
`default_nettype wire

/* File: sim/aadc_top_props.sv */
// checker for the post-processing top level ports
// assumes one clock and a synchronous active-high reset
`timescale 1ns/1ps
`default_nettype none
module aadc_top_props
(
  input wire logic clk,
  input wire logic rst,
  input wire logic converter_control_reg_vref,
  input wire logic [2:0] sample_averaging_control,
  input wire logic [31:0] sequence_step_control,
  input wire logic conv_done,
  input wire logic [9:0] conv_pos_data,
  input wire logic [9:0] conv_neg_data,
  input wire logic ext_ref_select,
  input wire logic [3:0] mux_pos_select,
  input wire logic [3:0] mux_neg_select,
  input wire logic diff_enable,
  input wire logic temp_select,
  input wire logic fifo_write,
  input wire logic [9:0] fifo_data,
  input wire logic [2:0] fifo_step,
  input wire logic step_interrupt,
  input wire logic seq_busy,
  input wire logic [7:0] cmp_interrupt,
  input wire logic [7:0] cmp_trigger
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // ==========================
  // conversions since last entry
  logic [7:0] cnt_q;
  logic [7:0] n_exp;
  // field value 7 clamps to 64
  assign n_exp = (sample_averaging_control == 3'h7) ? 8'h40 : (8'h01 << sample_averaging_control);
  always @(posedge clk)
  begin
    if (rst || fifo_write)
      cnt_q <= 8'h00;
    else if (conv_done && seq_busy)
      cnt_q <= cnt_q + 8'h01;
  end
  // ==========================
  // properties
  property p_pass;
    conv_done && seq_busy && sample_averaging_control == 3'h0 && !diff_enable && !temp_select
      |-> ##2 fifo_write && fifo_data == $past(conv_pos_data, 2);
  endproperty
  a_pass: assert property (p_pass) else $error("entry differs from raw conversion");
  property p_dzero;
    conv_done && seq_busy && sample_averaging_control == 3'h0 && diff_enable && conv_pos_data == conv_neg_data
      |-> ##2 fifo_write && fifo_data == 10'h1FF;
  endproperty
  a_dzero: assert property (p_dzero) else $error("zero difference not mid code");
  property p_pair;
    diff_enable |-> !mux_pos_select[0] && mux_neg_select == mux_pos_select + 4'h1;
  endproperty
  a_pair: assert property (p_pair) else $error("pair not even then odd input");
  property p_vref;
    !$past(rst) |-> ext_ref_select == $past(converter_control_reg_vref);
  endproperty
  a_vref: assert property (p_vref) else $error("reference select not followed");
  property p_count;
    fifo_write |-> cnt_q == n_exp;
  endproperty
  a_count: assert property (p_count) else $error("wrong conversions per entry");
  property p_ie;
    fifo_write || step_interrupt |-> fifo_write && step_interrupt == sequence_step_control[{fifo_step, 2'b10}];
  endproperty
  a_ie: assert property (p_ie) else $error("step interrupt mismatch");
  property p_cmpi;
    cmp_interrupt != 8'h00 |-> fifo_write && $onehot0(cmp_interrupt);
  endproperty
  a_cmpi: assert property (p_cmpi) else $error("stray comparator interrupt");
  property p_cmpt;
    cmp_trigger != 8'h00 |-> fifo_write && $onehot0(cmp_trigger);
  endproperty
  a_cmpt: assert property (p_cmpt) else $error("stray comparator trigger");
endmodule
bind aadc_top aadc_top_props u_props (.clk(clk), .rst(rst), .converter_control_reg_vref(converter_control_reg_vref),
  .sample_averaging_control(sample_averaging_control), .sequence_step_control(sequence_step_control),
  .conv_done(conv_done), .conv_pos_data(conv_pos_data), .conv_neg_data(conv_neg_data),
  .ext_ref_select(ext_ref_select), .mux_pos_select(mux_pos_select), .mux_neg_select(mux_neg_select),
  .diff_enable(diff_enable), .temp_select(temp_select), .fifo_write(fifo_write), .fifo_data(fifo_data),
  .fifo_step(fifo_step), .step_interrupt(step_interrupt), .seq_busy(seq_busy),
  .cmp_interrupt(cmp_interrupt), .cmp_trigger(cmp_trigger));
`default_nettype wire

/* File: sim/aadc_analog_model.sv */
// behavioural analog inputs and converter core
// assumes conv_start is a one-cycle pulse after a rising edge
`timescale 1ns/1ps
`default_nettype none
module aadc_analog_model
#(
  parameter logic [9:0] TEMP_CODE = 10'h2A5
)
(
  input wire logic clk,
  input wire logic conv_start,
  input wire logic [3:0] mux_pos_select,
  input wire logic [3:0] mux_neg_select,
  input wire logic diff_enable,
  input wire logic temp_select,
  input wire logic slow,
  input wire logic ramp,
  output logic conv_done,
  output logic [9:0] conv_pos_data,
  output logic [9:0] conv_neg_data,
  output logic [7:0] n_conv
);
  // input levels, set by the bench
  logic [9:0] chan [0:15];
  // small per-conversion offset to exercise truncation
  logic [1:0] ramp_q;
  initial
  begin
    conv_done = 1'b0;
    conv_pos_data = 10'h000;
    conv_neg_data = 10'h3FF;
    n_conv = 8'h00;
    ramp_q = 2'h0;
  end
  // one conversion per start; data lines scrambled outside done
  always
  begin
    @(posedge clk);
    #1;
    if (!ramp)
      ramp_q = 2'h0;
    if (conv_start === 1'b1)
    begin
      repeat (slow ? 7 : 2) @(posedge clk);
      #1;
      conv_done = 1'b1;
      conv_pos_data = temp_select ? TEMP_CODE : chan[mux_pos_select] + {8'h00, ramp_q};
      conv_neg_data = diff_enable ? chan[mux_neg_select] : ~conv_neg_data;
      n_conv = n_conv + 8'h01;
      ramp_q = ramp_q + 2'h1;
      @(posedge clk);
      #1;
      conv_done = 1'b0;
      conv_pos_data = ~conv_pos_data;
      conv_neg_data = ~conv_neg_data;
    end
  end
endmodule
`default_nettype wire

/* File: sim/tb_top.sv */
// self-checking bench for the post-processing block
// assumes the behavioural converter model on the far side
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic vref = 1'b0;
  logic [2:0] sac = 3'h0;
  logic [31:0] ctl = 32'h0000_0000;
  logic [31:0] sel = 32'h0000_0000;
  logic [7:0] sce = 8'h00;
  logic [23:0] scs = 24'h00_0000;
  logic trig = 1'b0;
  logic slow = 1'b0;
  logic ramp = 1'b0;
  logic [79:0] lo = 80'h0000;
  logic [79:0] hi = 80'h0000;
  logic [7:0] cie = 8'h00;
  logic [7:0] cte = 8'h00;
  logic [15:0] cim = 16'h0000;
  logic [15:0] cib = 16'h0000;
  logic [15:0] ctm = 16'h0000;
  logic [15:0] ctb = 16'h0000;
  wire cs, cd, er, de, ts, fw, si, busy;
  wire [9:0] pd, nd, fd;
  wire [3:0] mp, mn;
  wire [2:0] fs;
  wire [7:0] ci, ct, n_conv;
  int errors = 0;
  int checks_done = 0;
  int n_si;
  logic seen_ts;
  logic [12:0] q_data [$];
  logic [7:0] q_int [$];
  logic [7:0] q_trg [$];
  always #2.5 clk = ~clk;
  aadc_top DUT (.clk(clk), .rst(rst), .converter_control_reg_vref(vref), .sample_averaging_control(sac),
    .sequence_step_control(ctl), .sequence_input_select(sel), .step_compare_enable(sce),
    .step_compare_select(scs), .seq_trigger(trig), .conv_start(cs), .conv_done(cd), .conv_pos_data(pd),
    .conv_neg_data(nd), .ext_ref_select(er), .mux_pos_select(mp), .mux_neg_select(mn), .diff_enable(de),
    .temp_select(ts), .fifo_write(fw), .fifo_data(fd), .fifo_step(fs), .step_interrupt(si), .seq_busy(busy),
    .lower_limit(lo), .upper_limit(hi), .cmp_int_enable(cie), .cmp_trig_enable(cte), .cmp_int_mode(cim),
    .cmp_int_band(cib), .cmp_trig_mode(ctm), .cmp_trig_band(ctb), .cmp_interrupt(ci), .cmp_trigger(ct));
  aadc_analog_model model (.clk(clk), .conv_start(cs), .mux_pos_select(mp), .mux_neg_select(mn),
    .diff_enable(de), .temp_select(ts), .slow(slow), .ramp(ramp), .conv_done(cd), .conv_pos_data(pd),
    .conv_neg_data(nd), .n_conv(n_conv));
  // collect every entry with its comparator outputs
  always @(posedge clk)
  begin
    if (fw === 1'b1)
    begin
      q_data.push_back({fs, fd});
      q_int.push_back(ci);
      q_trg.push_back(ct);
    end
    if (si === 1'b1)
      n_si++;
    if (cs === 1'b1 && ts === 1'b1)
      seen_ts = 1'b1;
  end
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // one sequence: trigger, wait for idle, let last entry land
  task automatic run(input logic [31:0] c, input logic [31:0] s);
    int w;
    ctl = c;
    sel = s;
    q_data.delete();
    q_int.delete();
    q_trg.delete();
    n_si = 0;
    trig = 1'b1;
    @(posedge clk);
    #1;
    trig = 1'b0;
    @(posedge clk);
    #1;
    w = 0;
    while (busy !== 1'b0 && w < 2000)
    begin
      @(posedge clk);
      #1;
      w++;
    end
    check("seq_busy", busy, 16'h0000);
    @(posedge clk);
    #1;
  endtask
  // comparator 3, four routed entries per phase
  task automatic phase(input logic [7:0] m, input logic [39:0] v, input logic [3:0] ei, input logic [3:0] et);
    int k;
    cie = 8'h00;
    cte = 8'h00;
    @(posedge clk);
    #1;
    {cim[7:6], cib[7:6], ctm[7:6], ctb[7:6]} = m;
    cie = 8'h08;
    cte = 8'h08;
    for (k = 0; k < 4; k++)
    begin
      model.chan[8] = v[k*10 +: 10];
      run(32'h0000_0002, 32'h0000_0008);
      check("cmp_interrupt", q_int[0], ei[k] ? 16'h0008 : 16'h0000);
      check("cmp_trigger", q_trg[0], et[k] ? 16'h0008 : 16'h0000);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // hang guard, well beyond the expected run
  initial
  begin
    #200000;
    errors++;
    tally_and_finish();
  end
  initial
  begin
    int s;
    logic [7:0] n0;
    lo[39:30] = 10'h100;
    hi[39:30] = 10'h200;
    repeat (12) @(posedge clk);
    #1;
    rst = 1'b0;
    check("idle", {fw, busy, cs, si, er, 3'h0, ci}, 16'h0000);
    check("idle_trig", {8'h00, ct}, 16'h0000);
    $display("test reset done");
    model.chan[5] = 10'h3FF;
    model.chan[0] = 10'h000;
    run(32'h0000_0060, 32'h0000_0005);
    check("se_full", q_data[0], {3'h0, 10'h3FF});
    check("se_zero", q_data[1], {3'h1, 10'h000});
    check("step_int", n_si, 16'h0001);
    $display("test single done");
    model.chan[14] = 10'h300;
    model.chan[15] = 10'h100;
    model.chan[0] = 10'h155;
    model.chan[1] = 10'h155;
    model.chan[6] = 10'h000;
    model.chan[7] = 10'h3FF;
    run(32'h0000_0311, 32'h0000_0307);
    check("diff_pos", q_data[0], {3'h0, 10'h2FF});
    check("diff_zero", q_data[1], {3'h1, 10'h1FF});
    check("diff_neg", q_data[2], {3'h2, 10'h000});
    check("no_int", n_si, 16'h0000);
    $display("test diff done");
    model.chan[9] = 10'h1A5;
    for (s = 0; s < 8; s++)
    begin
      sac = s[2:0];
      slow = s[0];
      n0 = n_conv;
      run(32'h0000_0002, 32'h0000_0009);
      check("avg_entry", q_data[0], {3'h0, 10'h1A5});
      check("conv_count", n_conv - n0, (s == 7) ? 16'h0040 : (16'h0001 << s));
      check("entries", q_data.size(), 16'h0001);
    end
    $display("test avg_count done");
    sac = 3'h2;
    slow = 1'b0;
    ramp = 1'b1;
    model.chan[2] = 10'h100;
    model.chan[4] = 10'h200;
    model.chan[5] = 10'h200;
    run(32'h0000_0070, 32'h0000_0022);
    check("avg_trunc", q_data[0], {3'h0, 10'h101});
    check("avg_diff", q_data[1], {3'h1, 10'h1FF});
    check("avg_int", n_si, 16'h0001);
    $display("test avg_value done");
    sac = 3'h0;
    ramp = 1'b0;
    vref = 1'b1;
    seen_ts = 1'b0;
    model.chan[4] = 10'h111;
    run(32'h0000_000A, 32'h0000_0004);
    check("temp_entry", q_data[0], {3'h0, 10'h2A5});
    check("temp_sel", seen_ts, 16'h0001);
    check("ext_ref", er, 16'h0001);
    $display("test temp done");
    sce = 8'h01;
    scs = 24'h00_0003;
    phase({2'h1, 2'h3, 2'h0, 2'h0}, {10'h300, 10'h050, 10'h300, 10'h300}, 4'b1001, 4'b0100);
    phase({2'h2, 2'h3, 2'h1, 2'h1}, {10'h180, 10'h050, 10'h180, 10'h300}, 4'b0011, 4'b1010);
    phase({2'h0, 2'h2, 2'h3, 2'h0}, {10'h050, 10'h300, 10'h050, 10'h050}, 4'b0000, 4'b1001);
    // band edges: each limit itself falls in the band below it
    phase({2'h0, 2'h0, 2'h0, 2'h1}, {10'h201, 10'h200, 10'h101, 10'h100}, 4'b0001, 4'b0110);
    $display("test compare done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
